// file: verilog/sscc_pkg.sv
// Shared constants and types of the spread clock control block
package sscc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 20;          // System clock rate, MHz
    localparam int T_STABLE_US = 3000;    // Synthesizer settle, microseconds
    // Settle time as whole clock cycles
    localparam int STABLE_CYCLES = T_STABLE_US * CLK_MHZ;
    localparam int RAMP_DIV = 256;        // Cycles between spread steps

    // ************************************************************
    // Register map (index times four gives the byte address)
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int REG_CTRL0_IDX = 0;     // Spread and mode control
    localparam int REG_CTRL1_IDX = 1;     // Output enable, pump range
    localparam int REG_STATUS_IDX = 2;    // Live block state
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 4'(REG_CTRL0_IDX * 4);
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 4'(REG_CTRL1_IDX * 4);
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'(REG_STATUS_IDX * 4);

    // Control 0 fields
    localparam int C0_SS_LSB = 4;         // Spread select, four bits
    localparam int C0_FREQ = 3;           // 1 = 100 MHz, 0 = 96 MHz
    localparam int C0_SPREAD_EN = 1;      // Spread modulation on
    localparam int C0_SW_MODE = 0;        // 0 = pins, 1 = registers
    localparam logic C0_SPREAD_EN_RST = 1'h1;
    localparam logic C0_SW_MODE_RST = 1'h0;
    localparam logic [3:0] C0_SS_RST = 4'h0;

    // Control 1 fields
    localparam int C1_OUT_EN = 2;         // Differential output enable
    localparam int C1_CP_LSB = 0;         // Charge pump range, two bits
    localparam logic C1_OUT_EN_RST = 1'h1;
    localparam logic [1:0] CP_RST = 2'h0;

    // Status fields
    localparam int ST_STABLE = 0;         // Synthesizer settled
    localparam int ST_RUN = 1;            // Output clock is driven
    localparam int ST_RAMP = 2;           // Spread still moving
    localparam int ST_CODE_LSB = 4;       // Applied spread code

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Synchroniser lanes
    localparam int SY_REF = 0;
    localparam int SY_PD = 1;
    localparam int SY_FSEL = 2;
    localparam int SY_S_LSB = 3;
    localparam int SY_W = 6;

    // One accepted register write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } sscc_wreq_t;

    // Power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_SETTLE = 2'b01,
        PWR_ON = 2'b10,
        PWR_STOP = 2'b11
    } sscc_pwr_t;

endpackage : sscc_pkg

// file: verilog/sscc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sscc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // First stage, read only by the second

    // ************************************************************
    // Capture chain
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sscc_sync
`default_nettype wire

// file: verilog/sscc_axil.sv
// AXI4-Lite slave front end for the spread clock control registers
`timescale 1ns/1ns
`default_nettype none
module sscc_axil (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [sscc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [sscc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output sscc_pkg::sscc_wreq_t wr_req,
    output logic wr_fire,
    input wire logic wr_ok,
    output logic [sscc_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full_q; // Address held, waiting for data
    logic w_full_q;  // Data held, waiting for address
    logic aw_take;
    logic w_take;
    logic ar_take;

    // Channels stall while a response is still owed
    assign awready = !aw_full_q && !bvalid;
    assign wready = !w_full_q && !bvalid;
    assign arready = !rvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign ar_take = arvalid && arready;
    assign wr_fire = aw_full_q && w_full_q;
    assign rd_addr = araddr;

    // ************************************************************
    // Write path: address and data in either order
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            wr_req <= '0;
            bvalid <= 1'b0;
            bresp <= sscc_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                wr_req.addr <= awaddr;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                wr_req.data <= wdata;
                wr_req.strb <= wstrb;
            end
            // Both halves present: commit and answer
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? sscc_pkg::RESP_OKAY : sscc_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read path: data registered one cycle after the address
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= sscc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? sscc_pkg::RESP_OKAY : sscc_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    a_bresp_hold: assert property (@(posedge clk) disable iff (!nrst)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
endmodule : sscc_axil
`default_nettype wire

// file: verilog/sscc_ctrl.sv
// Spread clock control top: registers, power sequencing, output gating
//
// Summary of operation
// (R1) Spread code ramps stepwise to new value
// (R2) Reset: spread on, pin control mode
// (R3) Pin mode: upper select bits from straps
// (R4) Pin mode forces select lsb zero
// (R5) Register mode uses all four written bits
// (R6) Pump range resets to 00, writable
// (R7) Pump 11 gives slightly higher spread
// (R8) Pump 01 gives the largest spread
// (R9) Power-down pin synchronised before acting
// (R10) Power-down: outputs floated, oscillator, PLL off
// (R11) Clocks stop synchronously, no runt pulse
// (R12) Reference clock runs throughout power-down
// (R13) Outputs held stopped through settle interval
// (R14) Control 1 bit 2 enables output
// (R15) Output disable keeps PLL, oscillator running
// (R16) Disable floats output without glitch
// (R17) Enable restarts output cleanly
// (R18) Mode bit: 0 pins, 1 registers
// (R19) Spread enable bit: 0 off, 1 on
// (R20) Frequency bit: 1 100 MHz, 0 96 MHz
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sscc_ctrl #(
    parameter int STABLE_CYCLES = sscc_pkg::STABLE_CYCLES,
    parameter int RAMP_DIV = sscc_pkg::RAMP_DIV
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [sscc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [sscc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ref_clock_in,
    input wire logic power_down_request,
    input wire logic [3:1] spread_select_strap,
    input wire logic frequency_select_strap,
    output logic diff_clock_out,
    output logic diff_clock_out_n,
    output logic diff_clock_oe_n,
    output logic osc_enable,
    output logic pll_enable,
    output logic [3:0] spread_code,
    output logic spread_on,
    output logic [1:0] charge_pump,
    output logic frequency_select
);
    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int SCW = $clog2(STABLE_CYCLES + 1);
    localparam int RCW = $clog2(RAMP_DIV + 1);

    sscc_pkg::sscc_wreq_t wr_req;   // Committed write from the bus
    logic wr_fire;                  // One-cycle write strobe
    logic wr_ok;                    // Write address decodes
    logic [sscc_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [sscc_pkg::SY_W-1:0] sy_q; // Synchronised pins
    logic ref_s;                    // Reference clock, sampled
    logic pd_s;                     // Power-down request, sampled

    logic sw_mode_q;                // Register control selected
    logic spread_en_q;              // Spread modulation enable
    logic freq_reg_q;               // Frequency bit as held
    logic [3:0] ss_reg_q;           // Spread select as held
    logic out_en_q;                 // Output enable bit
    logic [1:0] cp_q;               // Charge pump range
    logic [1:0] strap_cnt_q;        // Wait for the sync chain to fill
    logic strap_done_q;             // Straps latched after release

    logic [3:0] target_code;        // Where the spread should end up
    logic [3:0] applied_q;          // Spread code now in use
    logic [RCW-1:0] ramp_cnt_q;
    logic ramp_tick;                // One-cycle step enable
    logic ramp_busy;

    sscc_pkg::sscc_pwr_t pwr_q;
    sscc_pkg::sscc_pwr_t pwr_d;
    logic [SCW-1:0] settle_cnt_q;
    logic settle_done;
    logic run_want;                 // Output ought to be running
    logic gate_q;                   // Gate on the output clock
    logic gate_d;

    logic hit_c0;
    logic hit_c1;
    logic hit_st;
    logic [7:0] c0_view;
    logic [7:0] c1_view;
    logic [7:0] st_view;

    // Step a code one unit toward its target
    function automatic logic [3:0] step_toward(input logic [3:0] cur,
                                               input logic [3:0] tgt);
        if (cur < tgt) begin
            step_toward = cur + 4'h1;
        end else if (cur > tgt) begin
            step_toward = cur - 4'h1;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // ************************************************************
    // Bus front end and pin synchronisers
    // ************************************************************
    sscc_axil u_axil (
        .clk(clk), .nrst(nrst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wr_req(wr_req), .wr_fire(wr_fire), .wr_ok(wr_ok),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
    );

    // The reference clock is slow next to clk, so sampling finds edges
    sscc_sync #(.W(sscc_pkg::SY_W)) u_sync (
        .clk(clk), .nrst(nrst),
        .d({spread_select_strap, frequency_select_strap,
            power_down_request, ref_clock_in}),
        .q(sy_q)
    );
    assign ref_s = sy_q[sscc_pkg::SY_REF];
    assign pd_s = sy_q[sscc_pkg::SY_PD]; // R9

    // ************************************************************
    // Register decode
    // ************************************************************
    assign hit_c0 = wr_req.addr == sscc_pkg::ADDR_CTRL0;
    assign hit_c1 = wr_req.addr == sscc_pkg::ADDR_CTRL1;
    assign wr_ok = hit_c0 || hit_c1; // Status is read-only
    assign rd_ok = rd_addr == sscc_pkg::ADDR_CTRL0
        || rd_addr == sscc_pkg::ADDR_CTRL1
        || rd_addr == sscc_pkg::ADDR_STATUS;

    // Pin mode shows the latched strap code with lsb zero, bit 2 reads 0
    assign c0_view = {target_code, frequency_select, 1'b0,
                      spread_en_q, sw_mode_q};
    assign c1_view = {5'h00, out_en_q, cp_q};
    assign st_view = {applied_q, 1'b0, ramp_busy, gate_q, settle_done};
    assign rd_data =
        rd_addr == sscc_pkg::ADDR_CTRL0 ? {24'h000000, c0_view} :
        rd_addr == sscc_pkg::ADDR_CTRL1 ? {24'h000000, c1_view} :
        rd_addr == sscc_pkg::ADDR_STATUS ? {24'h000000, st_view} :
        32'h00000000;

    // ************************************************************
    // Control registers
    // ************************************************************
    // Reset gives spread on and pin control; pump range back to 00
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sw_mode_q <= sscc_pkg::C0_SW_MODE_RST; // R2
            spread_en_q <= sscc_pkg::C0_SPREAD_EN_RST; // R2
            freq_reg_q <= 1'b0;
            ss_reg_q <= sscc_pkg::C0_SS_RST;
            out_en_q <= sscc_pkg::C1_OUT_EN_RST;
            cp_q <= sscc_pkg::CP_RST; // R6
        end else if (wr_fire && wr_req.strb[0]) begin
            if (hit_c0) begin
                ss_reg_q <= wr_req.data[sscc_pkg::C0_SS_LSB +: 4]; // R5
                freq_reg_q <= wr_req.data[sscc_pkg::C0_FREQ];
                spread_en_q <= wr_req.data[sscc_pkg::C0_SPREAD_EN]; // R19
                sw_mode_q <= wr_req.data[sscc_pkg::C0_SW_MODE]; // R18
            end
            if (hit_c1) begin
                out_en_q <= wr_req.data[sscc_pkg::C1_OUT_EN]; // R14
                cp_q <= wr_req.data[sscc_pkg::C1_CP_LSB +: 2]; // R6
            end
        end
    end

    // Straps are caught once the chain has filled after release.
    // Until then the pin-mode view is zero, a safe low spread.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            strap_done_q <= strap_cnt_q == 2'h2;
        end
    end

    logic [3:1] strap_q;
    logic fsel_strap_q;
    // Latched strap values
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_q <= 3'h0;
            fsel_strap_q <= 1'b0;
        end else if (!strap_done_q && strap_cnt_q == 2'h2) begin
            strap_q <= sy_q[sscc_pkg::SY_S_LSB +: 3]; // R3
            fsel_strap_q <= sy_q[sscc_pkg::SY_FSEL];
        end
    end

    // Mode bit picks the source of select and frequency
    assign target_code = sw_mode_q ? ss_reg_q : {strap_q, 1'b0}; // R3 R4 R5 R18
    assign frequency_select = sw_mode_q ? freq_reg_q : fsel_strap_q; // R20
    assign spread_on = spread_en_q; // R19
    // Pump 00 default, 11 one step up, 01 largest: the analog reads it
    assign charge_pump = cp_q; // R7 R8

    // ************************************************************
    // Spread ramp
    // ************************************************************
    // Stepping one code per tick keeps the modulation change gradual
    assign ramp_tick = ramp_cnt_q == RCW'(RAMP_DIV - 1);
    assign ramp_busy = applied_q != target_code;
    assign spread_code = applied_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ramp_cnt_q <= '0;
            applied_q <= sscc_pkg::C0_SS_RST;
        end else begin
            ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + RCW'(1);
            if (ramp_tick) begin
                applied_q <= step_toward(applied_q, target_code); // R1
            end
        end
    end

    // ************************************************************
    // Power sequencing
    // ************************************************************
    assign settle_done = pwr_q == sscc_pkg::PWR_ON;
    assign run_want = settle_done && out_en_q; // R14

    // Stop waits for the gate to close; settle waits the full interval
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            sscc_pkg::PWR_OFF: begin
                if (!pd_s) pwr_d = sscc_pkg::PWR_SETTLE;
            end
            sscc_pkg::PWR_SETTLE: begin
                if (pd_s) begin
                    pwr_d = sscc_pkg::PWR_OFF;
                end else if (settle_cnt_q == SCW'(STABLE_CYCLES - 1)) begin
                    pwr_d = sscc_pkg::PWR_ON; // R13
                end
            end
            sscc_pkg::PWR_ON: begin
                if (pd_s) pwr_d = sscc_pkg::PWR_STOP; // R9
            end
            sscc_pkg::PWR_STOP: begin
                if (!gate_q) pwr_d = sscc_pkg::PWR_OFF; // R11
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_q <= sscc_pkg::PWR_SETTLE;
            settle_cnt_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            settle_cnt_q <= pwr_q == sscc_pkg::PWR_SETTLE
                ? settle_cnt_q + SCW'(1) : '0;
        end
    end

    // Analog stays up through stop and settle; off only when idle
    assign osc_enable = pwr_q != sscc_pkg::PWR_OFF; // R10 R15
    assign pll_enable = pwr_q != sscc_pkg::PWR_OFF; // R10 R15

    // ************************************************************
    // Output gating
    // ************************************************************
    // The gate moves only while the sampled reference is low, so the
    // output never shows a shortened high phase. This relies on the
    // reference running while power-down is held.
    assign gate_d = ref_s ? gate_q : run_want; // R11 R12 R16 R17

    always_ff @(posedge clk) begin
        if (!nrst) begin
            gate_q <= 1'b0;
            diff_clock_out <= 1'b0;
            diff_clock_out_n <= 1'b0;
            diff_clock_oe_n <= 1'b1;
        end else begin
            gate_q <= gate_d;
            diff_clock_out <= gate_d & ref_s;
            diff_clock_out_n <= gate_d & ~ref_s;
            diff_clock_oe_n <= ~gate_d; // R10 R16
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_pd_seen;
        pwr_q == sscc_pkg::PWR_ON && pd_s;
    endsequence
    sequence s_gate_shut;
        pwr_q == sscc_pkg::PWR_STOP && !gate_q;
    endsequence

    a_pd_to_stop: assert property (@(posedge clk) disable iff (!nrst)
        s_pd_seen |=> pwr_q == sscc_pkg::PWR_STOP) // R9
        else $error("power-down not taken");
    a_stop_to_off: assert property (@(posedge clk) disable iff (!nrst)
        s_gate_shut |=> pwr_q == sscc_pkg::PWR_OFF && !osc_enable) // R10
        else $error("stopped clocks did not power off");
    a_off_floats: assert property (@(posedge clk) disable iff (!nrst)
        pwr_q == sscc_pkg::PWR_OFF |-> diff_clock_oe_n && !pll_enable) // R10
        else $error("output driven while powered off");
    a_stop_no_runt: assert property (@(posedge clk) disable iff (!nrst)
        $rose(diff_clock_oe_n) |-> !diff_clock_out && !$past(ref_s)) // R11 R16
        else $error("output floated mid pulse");
    a_start_clean: assert property (@(posedge clk) disable iff (!nrst)
        $fell(diff_clock_oe_n) |-> !diff_clock_out) // R17
        else $error("output started mid pulse");
    a_settle_hold: assert property (@(posedge clk) disable iff (!nrst)
        pwr_q == sscc_pkg::PWR_SETTLE |-> diff_clock_oe_n) // R13
        else $error("output ran before settle");
    a_pin_lsb_zero: assert property (@(posedge clk) disable iff (!nrst)
        !sw_mode_q |-> !target_code[0]) // R4
        else $error("select lsb not forced in pin mode");
    a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
        applied_q != $past(applied_q) |-> $past(ramp_tick)
        && (applied_q == $past(applied_q) + 4'h1
        || applied_q == $past(applied_q) - 4'h1)) // R1
        else $error("spread code jumped");
    a_disable_keeps: assert property (@(posedge clk) disable iff (!nrst)
        settle_done && !out_en_q |-> osc_enable && pll_enable) // R15
        else $error("analog stopped on output disable");
    a_reset_values: assert property (@(posedge clk) disable iff (1'b0)
        !nrst |=> spread_en_q && !sw_mode_q && cp_q == 2'h0) // R2 R6
        else $error("wrong values after reset");
endmodule : sscc_ctrl
`default_nettype wire

// file: verif/sscc_host.sv
// Register bus host model that programs the block
`timescale 1ns/1ns
`default_nettype none
module sscc_host (
    input wire logic clk,
    output logic [3:0] awaddr = 4'h0,
    output logic awvalid = 1'h0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] wstrb = 4'h0,
    output logic wvalid = 1'h0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'h0,
    output logic [3:0] araddr = 4'h0,
    output logic arvalid = 1'h0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'h0
);
    // Both halves offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'h0;
        // Let an edge pass so a following call never re-raises bready
        @(posedge clk);
    endtask : wr
    // Address held until taken, data taken with rvalid
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        // Let an edge pass so a following call never re-raises rready
        @(posedge clk);
    endtask : rd
endmodule : sscc_host
`default_nettype wire

// file: verif/spread_clock_control_test.sv
// Self-checking bench of the spread clock control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module spread_clock_control_test;
    logic clk = 1'h0, nrst = 1'h0, ref_clock_in = 1'h0;
    logic power_down_request = 1'h0, frequency_select_strap;
    logic [3:1] spread_select_strap;
    wire logic [3:0] awaddr, araddr, wstrb, spread_code;
    wire logic [31:0] wdata, rdata;
    wire logic [1:0] bresp, rresp, charge_pump;
    wire logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    wire logic arready, rvalid, rready, diff_clock_out, diff_clock_out_n;
    wire logic diff_clock_oe_n, osc_enable, pll_enable, spread_on;
    wire logic frequency_select;
    int mismatches = 0, n_compared = 0, cyc = 0, ss, sp;
    logic [31:0] d, e;
    logic [1:0] r;
    // ****************************************
    // Clocks, host, device
    // ****************************************
    always #25 clk = ~clk;
    always #200 ref_clock_in = ~ref_clock_in;
    sscc_host host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    sscc_ctrl #(.STABLE_CYCLES(20), .RAMP_DIV(4)) uut (.clk, .nrst,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .ref_clock_in, .power_down_request,
        .spread_select_strap, .frequency_select_strap, .diff_clock_out,
        .diff_clock_out_n, .diff_clock_oe_n, .osc_enable, .pll_enable,
        .spread_code, .spread_on, .charge_pump, .frequency_select);
    // Verdict and the end of the run
    task automatic end_sim;
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // Write that must be accepted
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        host.wr(a, v, r);
        `CHK(r, sscc_pkg::RESP_OKAY)
    endtask : wr
    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(7));
        spread_select_strap = 3'($urandom);
        frequency_select_strap = 1'($urandom);
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        repeat (80) @(posedge clk);
        host.rd(sscc_pkg::ADDR_CTRL0, d, r);
        e = {24'h0, spread_select_strap, 1'h0, frequency_select_strap, 3'h2};
        `CHK(d, e)
        `CHK(spread_code, {spread_select_strap, 1'h0})
        `CHK(frequency_select, frequency_select_strap)
        host.rd(sscc_pkg::ADDR_CTRL1, d, r);
        `CHK(d, 32'h4)
        // Register mode: every pump code, random spread target
        for (int i = 0; i < 4; i++) begin
            ss = $urandom_range(15, 0);
            sp = $urandom_range(1, 0);
            wr(sscc_pkg::ADDR_CTRL0, 32'(ss * 16 + i % 2 * 8 + sp * 2 + 1));
            wr(sscc_pkg::ADDR_CTRL1, 32'(4 + i));
            repeat (80) @(posedge clk);
            `CHK(spread_code, 4'(ss))
            `CHK(charge_pump, 2'(i))
            `CHK(spread_on, 1'(sp))
            `CHK(frequency_select, 1'(i % 2))
        end
        host.rd(4'hc, d, r);
        `CHK(r, sscc_pkg::RESP_SLVERR)
        // Output disable keeps the synthesizer alive
        wr(sscc_pkg::ADDR_CTRL1, 32'h0);
        repeat (20) @(posedge clk);
        `CHK({diff_clock_oe_n, diff_clock_out, pll_enable}, 3'h5)
        wr(sscc_pkg::ADDR_CTRL1, 32'h4);
        repeat (20) @(posedge clk);
        `CHK(diff_clock_oe_n, 1'h0)
        `CHK(diff_clock_out ^ diff_clock_out_n, 1'h1)
        // Power-down and the settle interval on the way back
        power_down_request <= 1'h1;
        repeat (20) @(posedge clk);
        `CHK({osc_enable, pll_enable, diff_clock_oe_n}, 3'h1)
        power_down_request <= 1'h0;
        repeat (12) @(posedge clk);
        `CHK(diff_clock_oe_n, 1'h1)
        repeat (40) @(posedge clk);
        `CHK(diff_clock_oe_n, 1'h0)
        `CHK(diff_clock_out ^ diff_clock_out_n, 1'h1)
        host.rd(sscc_pkg::ADDR_STATUS, d, r);
        `CHK(d, {24'h0, 4'(ss), 4'h3})
        end_sim();
    end
endmodule : spread_clock_control_test
`default_nettype wire
